// ==== design/sec_defines.vh ====
// Constants for the serial receiver equalizer control block.
// Assumes inclusion by every design file of the block; it holds definitions only.
`ifndef SEC_DEFINES_VH
`define SEC_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define SEC_IDX_GCTRL     10'h1c2
`define SEC_IDX_ZSEL      10'h1c3
`define SEC_IDX_IRQ_STAT  10'h1c4
`define SEC_IDX_IRQ_MASK  10'h1c5
`define SEC_IDX_LSET      10'h1d0
`define SEC_IDX_LSTAT     10'h1e0

// Reset values.
`define SEC_GCTRL_RST     8'h00
`define SEC_ZSEL_RST      8'h00
`define SEC_LSET_RST      8'h08
`define SEC_IRQ_RST       3'h0

// Global control field positions.
`define SEC_OVR_BIT       4
`define SEC_ZOVR_BIT      3
`define SEC_HOLD_BIT      2
`define SEC_MODE_HI       1
`define SEC_MODE_LO       0

// Lane setting and lane status field positions.
`define SEC_BOOST_HI      6
`define SEC_BOOST_LO      5
`define SEC_LEVEL_HI      4
`define SEC_LEVEL_LO      0
`define SEC_OVER_BIT      6
`define SEC_UNDER_BIT     5

// Equalizer modes.
`define SEC_MODE_OFF      2'h0
`define SEC_MODE_ON       2'h1
`define SEC_MODE_PRE      2'h2
`define SEC_MODE_POST     2'h3

// Line rates.
`define SEC_RATE_FULL     2'h0
`define SEC_RATE_HALF     2'h1
`define SEC_RATE_QUARTER  2'h2
`define SEC_RATE_EIGHTH   2'h3

// Zero frequency codes and their corner frequencies in MHz.
`define SEC_ZC_365        5'h1f
`define SEC_ZC_275        5'h1e
`define SEC_ZC_195        5'h1d
`define SEC_ZC_140        5'h1b
`define SEC_ZC_105        5'h19
`define SEC_ZC_75         5'h10
`define SEC_ZC_55         5'h08
`define SEC_ZC_50         5'h00
`define SEC_MHZ_365       9'h16d
`define SEC_MHZ_275       9'h113
`define SEC_MHZ_195       9'h0c3
`define SEC_MHZ_140       9'h08c
`define SEC_MHZ_105       9'h069
`define SEC_MHZ_75        9'h04b
`define SEC_MHZ_55        9'h037
`define SEC_MHZ_50        9'h032

// Interrupt status bits.
`define SEC_IRQ_OVER      0
`define SEC_IRQ_UNDER     1
`define SEC_IRQ_LEVEL     2

`endif

// ==== design/sec_zero_sel.v ====
// Zero frequency selection shared by all lanes.
// Assumes the line rate and control inputs are synchronous to pclk.
`timescale 1ns/100ps
`include "sec_defines.vh"

module sec_zero_sel (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       zero_override,
   input  wire [4:0] zero_frequency_code,
   input  wire [1:0] line_rate,
   output reg  [4:0] zero_code_q,
   output reg  [8:0] zero_mhz_q
);

   reg [4:0] zero_code_d;

   function [8:0] code_mhz;
      input [4:0] c;
      begin
         case (c)
            `SEC_ZC_365: code_mhz = `SEC_MHZ_365;
            `SEC_ZC_275: code_mhz = `SEC_MHZ_275;
            `SEC_ZC_195: code_mhz = `SEC_MHZ_195;
            `SEC_ZC_140: code_mhz = `SEC_MHZ_140;
            `SEC_ZC_105: code_mhz = `SEC_MHZ_105;
            `SEC_ZC_75:  code_mhz = `SEC_MHZ_75;
            `SEC_ZC_55:  code_mhz = `SEC_MHZ_55;
            `SEC_ZC_50:  code_mhz = `SEC_MHZ_50;
            default:     code_mhz = 9'h000;
         endcase
      end
   endfunction

   always @* begin
      if (zero_override) begin
         zero_code_d = zero_frequency_code;
      end else begin
         case (line_rate)
            `SEC_RATE_FULL,
            `SEC_RATE_HALF:    zero_code_d = `SEC_ZC_365;
            `SEC_RATE_QUARTER: zero_code_d = `SEC_ZC_140;
            default:           zero_code_d = `SEC_ZC_55;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_code_q <= `SEC_ZC_365;
         zero_mhz_q  <= `SEC_MHZ_365;
      end else begin
         zero_code_q <= zero_code_d;
         zero_mhz_q  <= code_mhz(zero_code_d);
      end
   end

endmodule

// ==== design/sec_lane_stat.v ====
// Per-lane status capture: level in effect and cursor analysis flags.
// Assumes thermometer levels and flags arrive synchronous to pclk.
`timescale 1ns/100ps
`include "sec_defines.vh"

module sec_lane_stat #(
   parameter LANES = 16,
   parameter TW    = 16
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire [LANES*TW-1:0] therm_level,
   input  wire [LANES-1:0]  over_in,
   input  wire [LANES-1:0]  under_in,
   output reg  [LANES*5-1:0] level_in_effect_q,
   output reg  [LANES-1:0]  analysis_over_flag_q,
   output reg  [LANES-1:0]  analysis_under_flag_q
);

   function [4:0] ones;
      input [TW-1:0] t;
      integer i;
      begin
         ones = 5'h00;
         for (i = 0; i < TW; i = i + 1) begin
            ones = ones + {4'h0, t[i]};
         end
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : lane
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               level_in_effect_q[g*5 +: 5] <= 5'h00;
            end else begin
               level_in_effect_q[g*5 +: 5] <= ones(therm_level[g*TW +: TW]);
            end
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analysis_over_flag_q  <= {LANES{1'b0}};
         analysis_under_flag_q <= {LANES{1'b0}};
      end else begin
         analysis_over_flag_q  <= over_in;
         analysis_under_flag_q <= under_in;
      end
   end

endmodule

// ==== design/sec_ctrl.v ====
// Register bank controlling the receive equalizers of a multi-lane serial receiver.
// Assumes an APB master on pclk and analog equalizer signals synchronous to pclk.
`timescale 1ns/100ps
`include "sec_defines.vh"

module sec_ctrl #(
   parameter LANES = 16,
   parameter TW    = 16
) (
   input  wire                 pclk,
   input  wire                 presetn,
   input  wire [11:0]          paddr,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   input  wire [1:0]           line_rate,
   input  wire [LANES*TW-1:0]  therm_level,
   input  wire [LANES-1:0]     over_in,
   input  wire [LANES-1:0]     under_in,
   output reg  [1:0]           equalizer_mode_select,
   output reg                  eq_flat_max_gain,
   output reg                  eq_adaptive,
   output reg                  eq_pre_analysis,
   output reg                  eq_post_analysis,
   output reg                  level_override,
   output reg                  adaptation_hold,
   output reg  [LANES*5-1:0]   lane_level_code,
   output reg  [LANES*2-1:0]   lane_gain_boost,
   output wire [4:0]           zero_code_q,
   output wire [8:0]           zero_mhz_q,
   output reg                  irq
);

   reg  [7:0]         gctrl_q;
   reg  [7:0]         zsel_q;
   reg  [7:0]         lset_q [0:LANES-1];
   reg  [2:0]         irq_stat_q;
   reg  [2:0]         irq_mask_q;
   reg  [LANES-1:0]   over_prev_q;
   reg  [LANES-1:0]   under_prev_q;
   reg  [LANES*5-1:0] level_prev_q;
   reg  [31:0]        rdata_d;
   reg                err_d;
   reg  [2:0]         ev_d;

   wire [LANES*5-1:0] level_in_effect_q;
   wire [LANES-1:0]   analysis_over_flag_q;
   wire [LANES-1:0]   analysis_under_flag_q;
   wire [9:0]         idx;
   wire               aligned;
   wire               setup_ph;
   wire               wr_acc;
   wire [1:0]         mode;
   wire [5:0]         sel;
   wire               we_gctrl;
   wire               we_zsel;
   wire               we_istat;
   wire               we_imask;
   wire [LANES-1:0]   we_lset;
   reg                flat_d;
   reg                adaptive_d;
   reg                pre_d;
   reg                post_d;
   reg                override_d;
   reg                hold_d;

   // One-hot selects of the register map regions.
   localparam [5:0] SEL_GCTRL = 6'h01;
   localparam [5:0] SEL_ZSEL  = 6'h02;
   localparam [5:0] SEL_ISTAT = 6'h04;
   localparam [5:0] SEL_IMASK = 6'h08;
   localparam [5:0] SEL_LSET  = 6'h10;
   localparam [5:0] SEL_LSTAT = 6'h20;

   assign idx      = paddr[11:2];
   assign aligned  = (paddr[1:0] == 2'h0);
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pready & pwrite & aligned;
   assign mode     = gctrl_q[`SEC_MODE_HI:`SEC_MODE_LO];
   assign sel      = map_sel(idx);
   assign we_gctrl = wr_acc & (sel == SEL_GCTRL);
   assign we_zsel  = wr_acc & (sel == SEL_ZSEL);
   assign we_istat = wr_acc & (sel == SEL_ISTAT);
   assign we_imask = wr_acc & (sel == SEL_IMASK);

   function is_lset;
      input [9:0] a;
      begin
         is_lset = (a >= `SEC_IDX_LSET) && (a < `SEC_IDX_LSET + LANES);
      end
   endfunction

   function is_lstat;
      input [9:0] a;
      begin
         is_lstat = (a >= `SEC_IDX_LSTAT) && (a < `SEC_IDX_LSTAT + LANES);
      end
   endfunction

   // one-hot map decode shared by the read mux and every write enable except the lane setting ones.
   function [5:0] map_sel;
      input [9:0] a;
      begin
         map_sel = 6'h00;
         if (a == `SEC_IDX_GCTRL) begin
            map_sel = SEL_GCTRL;
         end else if (a == `SEC_IDX_ZSEL) begin
            map_sel = SEL_ZSEL;
         end else if (a == `SEC_IDX_IRQ_STAT) begin
            map_sel = SEL_ISTAT;
         end else if (a == `SEC_IDX_IRQ_MASK) begin
            map_sel = SEL_IMASK;
         end else if (is_lset(a)) begin
            map_sel = SEL_LSET;
         end else if (is_lstat(a)) begin
            map_sel = SEL_LSTAT;
         end
      end
   endfunction

   // over and under flags sit above the level in a lane status byte.
   function [7:0] lane_status;
      input       over;
      input       under;
      input [4:0] level;
      begin
         lane_status                 = 8'h00;
         lane_status[`SEC_OVER_BIT]  = over;
         lane_status[`SEC_UNDER_BIT] = under;
         lane_status[4:0]            = level;
      end
   endfunction

   sec_lane_stat #(
      .LANES (LANES),
      .TW    (TW)
   ) u_stat (
      .pclk                  (pclk),
      .presetn               (presetn),
      .therm_level           (therm_level),
      .over_in               (over_in),
      .under_in              (under_in),
      .level_in_effect_q     (level_in_effect_q),
      .analysis_over_flag_q  (analysis_over_flag_q),
      .analysis_under_flag_q (analysis_under_flag_q)
   );

   sec_zero_sel u_zero (
      .pclk                (pclk),
      .presetn             (presetn),
      .zero_override       (gctrl_q[`SEC_ZOVR_BIT]),
      .zero_frequency_code (zsel_q[4:0]),
      .line_rate           (line_rate),
      .zero_code_q         (zero_code_q),
      .zero_mhz_q          (zero_mhz_q)
   );

   // Global control; reserved bits are stored as written.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gctrl_q <= `SEC_GCTRL_RST;
      end else if (we_gctrl) begin
         gctrl_q <= pwdata[7:0];
      end
   end

   // Zero select; reserved bits are stored as written.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zsel_q <= `SEC_ZSEL_RST;
      end else if (we_zsel) begin
         zsel_q <= pwdata[7:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : lane
         // lane n lives at the base index plus n.
         assign we_lset[g] = wr_acc & (idx == `SEC_IDX_LSET + g);

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lset_q[g] <= `SEC_LSET_RST;
            end else if (we_lset[g]) begin
               lset_q[g] <= pwdata[7:0];
            end
         end

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lane_level_code[g*5 +: 5] <= 5'h08;
               lane_gain_boost[g*2 +: 2] <= 2'h0;
            end else begin
               // level passed on unclamped; software keeps it in range.
               lane_level_code[g*5 +: 5] <= lset_q[g][`SEC_LEVEL_HI:`SEC_LEVEL_LO];
               lane_gain_boost[g*2 +: 2] <= lset_q[g][`SEC_BOOST_HI:`SEC_BOOST_LO];
            end
         end
      end
   endgenerate

   // one mode for all lanes, decoded once for every output.
   always @* begin
      flat_d     = (mode == `SEC_MODE_OFF);
      pre_d      = (mode == `SEC_MODE_PRE);
      post_d     = (mode == `SEC_MODE_POST);
      adaptive_d = (mode == `SEC_MODE_ON) & ~gctrl_q[`SEC_OVR_BIT];
      override_d = (mode == `SEC_MODE_ON) & gctrl_q[`SEC_OVR_BIT];
      // hold only in fully adaptive operation.
      hold_d     = adaptive_d & gctrl_q[`SEC_HOLD_BIT];
   end

   // Mode decode is registered so the analog side sees glitch-free levels.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         equalizer_mode_select <= `SEC_MODE_OFF;
         eq_flat_max_gain      <= 1'b1;
         eq_adaptive           <= 1'b0;
         eq_pre_analysis       <= 1'b0;
         eq_post_analysis      <= 1'b0;
         level_override        <= 1'b0;
         adaptation_hold       <= 1'b0;
      end else begin
         equalizer_mode_select <= mode;
         eq_flat_max_gain      <= flat_d;
         eq_adaptive           <= adaptive_d;
         eq_pre_analysis       <= pre_d;
         eq_post_analysis      <= post_d;
         level_override        <= override_d;
         adaptation_hold       <= hold_d;
      end
   end

   // Events: a new over flag, a new under flag, or any change of a level in effect.
   always @* begin
      ev_d                 = 3'h0;
      ev_d[`SEC_IRQ_OVER]  = |(analysis_over_flag_q & ~over_prev_q);
      ev_d[`SEC_IRQ_UNDER] = |(analysis_under_flag_q & ~under_prev_q);
      ev_d[`SEC_IRQ_LEVEL] = (level_in_effect_q != level_prev_q);
   end

   // Previous flag and level values for edge detection.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         over_prev_q  <= {LANES{1'b0}};
         under_prev_q <= {LANES{1'b0}};
         level_prev_q <= {LANES*5{1'b0}};
      end else begin
         over_prev_q  <= analysis_over_flag_q;
         under_prev_q <= analysis_under_flag_q;
         level_prev_q <= level_in_effect_q;
      end
   end

   // A new event beats a write-one clear in the same cycle, so none is lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= `SEC_IRQ_RST;
      end else if (we_istat) begin
         irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev_d;
      end else begin
         irq_stat_q <= irq_stat_q | ev_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= `SEC_IRQ_RST;
      end else if (we_imask) begin
         irq_mask_q <= pwdata[2:0];
      end
   end

   // The interrupt is a flop so the pin never glitches on a mask write.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read mux; unmapped or unaligned addresses read zero and flag an error.
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (!aligned) begin
         err_d = 1'b1;
      end else begin
         case (sel)
            SEL_GCTRL: rdata_d[7:0] = gctrl_q;
            SEL_ZSEL:  rdata_d[7:0] = zsel_q;
            SEL_ISTAT: rdata_d[2:0] = irq_stat_q;
            SEL_IMASK: rdata_d[2:0] = irq_mask_q;
            SEL_LSET:  rdata_d[7:0] = lset_q[idx[3:0]];
            // level in effect, with the analysis flags above it.
            SEL_LSTAT: rdata_d[7:0] = lane_status(analysis_over_flag_q[idx[3:0]],
                                                  analysis_under_flag_q[idx[3:0]],
                                                  level_in_effect_q[idx[3:0]*5 +: 5]);
            default:   err_d = 1'b1;
         endcase
      end
   end

   // Zero wait states: ready rises after reset and stays high.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
      end
   end

   // Data and error are captured in the setup cycle and stand until the next one.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr <= err_d;
      end
   end

endmodule

// ==== sim/sec_ctrl_sva.sv ====
// Port assertions for the equalizer control register block.
// Assumes binding to sec_ctrl, one clock pclk and active-low presetn.
`timescale 1ns/100ps
module sec_ctrl_sva #(
   parameter LANES = 16,
   parameter TW    = 16
) (
   input wire               pclk,
   input wire               presetn,
   input wire [11:0]        paddr,
   input wire               psel,
   input wire               penable,
   input wire               pwrite,
   input wire [31:0]        pwdata,
   input wire               pready,
   input wire               pslverr,
   input wire [1:0]         equalizer_mode_select,
   input wire               eq_flat_max_gain,
   input wire               eq_adaptive,
   input wire               eq_pre_analysis,
   input wire               eq_post_analysis,
   input wire               level_override,
   input wire               adaptation_hold,
   input wire [LANES*5-1:0] lane_level_code,
   input wire [LANES*2-1:0] lane_gain_boost,
   input wire [4:0]         zero_code_q,
   input wire [8:0]         zero_mhz_q
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [9:0] idx = paddr[11:2];
   // Unaligned addresses are refused as well as holes in the map.
   wire       ok  = paddr[1:0] == 2'b00 &&
                    ((idx >= 10'h1c2 && idx <= 10'h1c5) || (idx >= 10'h1d0 && idx <= 10'h1ef));
   function automatic [8:0] mhz(input [4:0] c);
      case (c)
         5'h1f: mhz = 9'h16d;
         5'h1e: mhz = 9'h113;
         5'h1d: mhz = 9'h0c3;
         5'h1b: mhz = 9'h08c;
         5'h19: mhz = 9'h069;
         5'h10: mhz = 9'h04b;
         5'h08: mhz = 9'h037;
         5'h00: mhz = 9'h032;
         default: mhz = 9'h000;
      endcase
   endfunction
   sequence wr_glb;
      psel && penable && pready && pwrite && paddr == 12'h708;
   endsequence
   sequence wr_ln0;
      psel && penable && pready && pwrite && paddr == 12'h740;
   endsequence
   mode_off_a: assert property (
      equalizer_mode_select == 2'h0 |-> eq_flat_max_gain && !eq_adaptive) else $error("mode off");
   mode_pre_a: assert property (
      equalizer_mode_select == 2'h2 |-> eq_pre_analysis && !eq_post_analysis && !level_override)
      else $error("mode pre");
   mode_post_a: assert property (
      equalizer_mode_select == 2'h3 |-> eq_post_analysis && !adaptation_hold) else $error("post");
   adapt_only_a: assert property (
      eq_adaptive |-> equalizer_mode_select == 2'h1 && !level_override) else $error("adaptive");
   override_mode_a: assert property (
      level_override |-> equalizer_mode_select == 2'h1 && !adaptation_hold) else $error("ovr");
   hold_adapt_a: assert property (adaptation_hold |-> eq_adaptive) else $error("hold");
   mode_write_a: assert property (wr_glb |-> ##2
      equalizer_mode_select == $past(pwdata[1:0], 2)) else $error("mode write");
   lane_write_a: assert property (wr_ln0 |-> ##2
      lane_gain_boost[1:0] == $past(pwdata[6:5], 2) && lane_level_code[4:0] == $past(pwdata[4:0], 2))
      else $error("lane write");
   zero_map_a: assert property (
      $stable(zero_code_q) |-> zero_mhz_q == mhz(zero_code_q)) else $error("zero map");
   ready_stays_a: assert property (pready |=> pready) else $error("pready dropped");
   map_error_a: assert property (
      psel && !penable |=> pslverr == !$past(ok)) else $error("slave error");
endmodule

bind sec_ctrl sec_ctrl_sva #(.LANES(LANES), .TW(TW)) u_sva (.pclk, .presetn, .paddr, .psel,
   .penable, .pwrite, .pwdata, .pready, .pslverr, .equalizer_mode_select, .eq_flat_max_gain,
   .eq_adaptive, .eq_pre_analysis, .eq_post_analysis, .level_override, .adaptation_hold,
   .lane_level_code, .lane_gain_boost, .zero_code_q, .zero_mhz_q);

// ==== sim/sec_ctrl_tb.sv ====
// Self-checking bench for the equalizer control register block.
// Assumes the design files and the bound checker compile alongside.
`timescale 1ns/100ps
module sec_ctrl_tb;
   logic         pclk, presetn, psel, penable, pwrite, err;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, rd;
   logic [1:0]   line_rate;
   logic [255:0] therm_level;
   logic [15:0]  over_in, under_in;
   wire  [31:0]  prdata, lane_gain_boost;
   wire          pready, pslverr, eq_flat_max_gain, eq_adaptive, eq_pre_analysis;
   wire          eq_post_analysis, level_override, adaptation_hold, irq;
   wire  [1:0]   equalizer_mode_select;
   wire  [79:0]  lane_level_code;
   wire  [4:0]   zero_code_q;
   wire  [8:0]   zero_mhz_q;
   int           mismatches = 0, compares = 0, cyc = 0;
   logic [7:0]   lset [16];
   logic [4:0]   lv [16];
   logic [4:0]   zc [8] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h19, 5'h10, 5'h08, 5'h00};
   logic [8:0]   zm [8] = '{9'h16d, 9'h113, 9'h0c3, 9'h08c, 9'h069, 9'h04b, 9'h037, 9'h032};

   sec_ctrl uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .line_rate, .therm_level, .over_in, .under_in, .equalizer_mode_select,
      .eq_flat_max_gain, .eq_adaptive, .eq_pre_analysis, .eq_post_analysis, .level_override,
      .adaptation_hold, .lane_level_code, .lane_gain_boost, .zero_code_q, .zero_mhz_q, .irq);

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // The whole run needs under two thousand cycles, so this only trips on a hang.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cy(input int k);
      repeat (k) @(posedge pclk);
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready.
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wt(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
      chk("pslverr", 32'h0, {31'h0, err});
   endtask

   initial begin
      int i, k;
      logic [7:0] g, z;
      logic [4:0] ez;
      logic [1:0] m;
      {psel, penable, pwrite} = 3'b000;
      {paddr, pwdata, line_rate, over_in, under_in} = '0;
      therm_level = '0;
      presetn = 1'b0;
      void'($urandom(32'h170d));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk("flat", 32'h1, eq_flat_max_gain);
      chk("zcode", 32'h1f, zero_code_q);
      rchk("glb", 12'h708, 32'h0);
      rchk("zero", 12'h70c, 32'h0);
      for (i = 0; i < 16; i++) rchk("lset", 12'(12'h740 + 4 * i), 32'h08);
      for (i = 0; i < 32; i++) begin
         g = {3'($urandom), i[4:0]};
         z = {3'($urandom), zc[i % 8]};
         line_rate <= 2'($urandom);
         wt(12'h70c, z);
         wt(12'h708, g);
         cy(3);
         m = g[1:0];
         ez = g[3] ? z[4:0] : (line_rate == 2'h2 ? 5'h1b : line_rate == 2'h3 ? 5'h08 : 5'h1f);
         k = 0;
         while (zc[k] !== ez) k++;
         chk("mode", m, equalizer_mode_select);
         chk("flat", m == 0, eq_flat_max_gain);
         chk("adapt", m == 1 && !g[4], eq_adaptive);
         chk("pre", m == 2, eq_pre_analysis);
         chk("post", m == 3, eq_post_analysis);
         chk("ovr", m == 1 && g[4], level_override);
         chk("hold", m == 1 && !g[4] && g[2], adaptation_hold);
         chk("zcode", ez, zero_code_q);
         chk("zmhz", zm[k], zero_mhz_q);
         rchk("glb", 12'h708, g);
         rchk("zero", 12'h70c, z);
      end
      for (i = 0; i < 16; i++) begin
         lset[i] = {1'($urandom), 2'($urandom), 5'($urandom_range(16))};
         lset[i][4:0] = (i == 0) ? 5'd16 : (i == 15) ? 5'd0 : lset[i][4:0];
         wt(12'(12'h740 + 4 * i), lset[i]);
         k = (i < 2) ? 16 * (1 - i) : $urandom_range(16);
         lv[i] = 5'(k);
         therm_level[16 * i +: 16] <= 16'((17'h1 << k) - 1);
      end
      over_in <= 16'($urandom);
      under_in <= 16'($urandom);
      cy(3);
      for (i = 0; i < 16; i++) begin
         chk("level", lset[i][4:0], lane_level_code[5 * i +: 5]);
         chk("boost", lset[i][6:5], lane_gain_boost[2 * i +: 2]);
         rchk("lset", 12'(12'h740 + 4 * i), lset[i]);
         rchk("lstat", 12'(12'h780 + 4 * i), {over_in[i], under_in[i], lv[i]});
      end
      wt(12'h780, 32'hff);
      rchk("lstat", 12'h780, {over_in[0], under_in[0], lv[0]});
      apb(1'b0, 12'h718, 32'h0);
      chk("hole data", 32'h0, rd);
      chk("hole err", 32'h1, err);
      apb(1'b0, 12'h709, 32'h0);
      chk("unaligned err", 32'h1, err);
      over_in <= 16'h0;
      under_in <= 16'h0;
      cy(4);
      wt(12'h714, 32'h0);
      wt(12'h710, 32'h7);
      rchk("istat", 12'h710, 32'h0);
      over_in <= 16'h0020;
      cy(4);
      rchk("istat", 12'h710, 32'h1);
      chk("irq", 32'h0, irq);
      wt(12'h714, 32'h1);
      cy(2);
      chk("irq", 32'h1, irq);
      wt(12'h710, 32'h1);
      cy(2);
      chk("irq", 32'h0, irq);
      under_in <= 16'h8000;
      cy(4);
      chk("irq", 32'h0, irq);
      rchk("istat", 12'h710, 32'h2);
      wt(12'h714, 32'h7);
      cy(2);
      chk("irq", 32'h1, irq);
      wt(12'h710, 32'h7);
      therm_level[15:0] <= 16'h0001;
      cy(4);
      rchk("istat", 12'h710, 32'h4);
      chk("irq", 32'h1, irq);
      rchk("lstat", 12'h780, 32'h01);
      complete_run();
   end
endmodule
